/* hw/flash_host_pkg.sv */
package flash_host_pkg;
    // Array geometry
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int SECTOR_BYTES = 256;
    localparam int SECTOR_LSB = $clog2(SECTOR_BYTES);

    // Command codes
    localparam logic [7:0] CMD_SECTOR_SETUP = 8'h20;
    localparam logic [7:0] CMD_SECTOR_EXEC = 8'hD0;
    localparam logic [7:0] CMD_CHIP_SETUP = 8'h30;
    localparam logic [7:0] CMD_CHIP_EXEC = 8'h30;
    localparam logic [7:0] CMD_RESET = 8'hFF;

    // Status bit positions in a read byte
    localparam int POLL_STATUS_BIT = 7;
    localparam int TOGGLE_STATUS_BIT = 6;

    // Timing at the 50 MHz system clock
    localparam int CLK_KHZ = 50000;
    localparam int CLK_NS = 20;
    localparam int WE_PULSE_NS = 100;
    localparam int READ_ACCESS_NS = 200;
    localparam int SECTOR_ERASE_MS = 4;
    localparam int CHIP_ERASE_MS = 20;
    localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_MS * CLK_KHZ;
    localparam int CHIP_ERASE_CYC = CHIP_ERASE_MS * CLK_KHZ;
    localparam int TIMER_W = 21;
    localparam int CNT_W = 4;

    // Seven-read sequence that lifts the write lock, first read at index 0
    localparam int UNLOCK_READS = 7;
    localparam logic [6:0][18:0] UNLOCK_ADDR = {
        19'h041A, 19'h0419, 19'h041B, 19'h0418, 19'h1822, 19'h1820, 19'h1823};

    typedef enum logic [1:0] {
        OP_SECTOR_ERASE = 2'b00,
        OP_CHIP_ERASE = 2'b01,
        OP_ABORT = 2'b10,
        OP_UNLOCK = 2'b11
    } op_t;

    typedef enum logic [1:0] {
        RES_OK = 2'b00,
        RES_ABORTED = 2'b01,
        RES_TIMEOUT = 2'b10
    } result_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_WR_ADDR = 3'b001,
        S_WR_PULSE = 3'b010,
        S_WR_END = 3'b011,
        S_RD = 3'b100,
        S_RD_END = 3'b101,
        S_NEXT = 3'b110
    } state_t;

    typedef struct packed {
        logic valid;
        op_t op;
        logic [ADDR_W-1:0] addr;
    } host_req_t;

    typedef struct packed {
        logic busy;
        logic done;
        result_t result;
    } host_resp_t;

    typedef struct packed {
        logic ce_b;
        logic we_b;
        logic oe_b;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
    } flash_pins_t;

    typedef struct packed {
        state_t state;
        logic [2:0] step;
        logic [CNT_W-1:0] cnt;
        logic [TIMER_W-1:0] timer;
        logic prev_valid;
        logic prev_toggle;
        op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] cmd;
        result_t result;
        flash_pins_t pins;
        host_resp_t resp;
    } ctrl_t;
endpackage : flash_host_pkg

/* hw/flash_erase_host.sv */
// Contract
// - Commands written with strobe low, select low
// - Sector erase is 20H then D0H
// - Sector erase may be repeated safely
// - Chip erase is 30H then 30H
// - Reset aborts chip erase; reissue allowed
// - FFH after setup aborts, memory unchanged
module flash_erase_host #(
    parameter int unsigned SECTOR_LIMIT = flash_host_pkg::SECTOR_ERASE_CYC,
    parameter int unsigned CHIP_LIMIT = flash_host_pkg::CHIP_ERASE_CYC
) (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_en,
    // User command port
    input wire flash_host_pkg::host_req_t i_req,
    input wire logic i_abort,
    output flash_host_pkg::host_resp_t o_resp,
    // Flash pins
    input wire logic [flash_host_pkg::DATA_W-1:0] i_dq,
    output flash_host_pkg::flash_pins_t o_pins
);
    import flash_host_pkg::*;

    ctrl_t q;
    ctrl_t next_q;
    logic [TIMER_W-1:0] limit;
    logic poll_done;

    assign limit = (q.op == OP_CHIP_ERASE) ? TIMER_W'(CHIP_LIMIT) : TIMER_W'(SECTOR_LIMIT);
    // Erased byte reads all ones; done when poll bit true and toggle steady
    assign poll_done = q.prev_valid && (i_dq[TOGGLE_STATUS_BIT] == q.prev_toggle)
        && i_dq[POLL_STATUS_BIT];

    always_comb begin
        next_q = q;
        next_q.resp.done = 1'b0;
        // Erase runs on the flash's own timer from the execute write onward
        if (q.step == 3'd2 && q.op != OP_UNLOCK && q.op != OP_ABORT && q.timer != '1) begin
            next_q.timer = q.timer + TIMER_W'(1);
        end
        case (q.state)
            S_IDLE: begin
                next_q.pins.ce_b = 1'b1;
                next_q.pins.we_b = 1'b1;
                next_q.pins.oe_b = 1'b1;
                next_q.pins.dq_oe = 1'b0;
                if (i_req.valid) begin
                    next_q.op = i_req.op;
                    next_q.addr = i_req.addr;
                    next_q.step = 3'd0;
                    next_q.timer = '0;
                    next_q.prev_valid = 1'b0;
                    next_q.resp.busy = 1'b1;
                    next_q.state = S_NEXT;
                end
            end
            S_NEXT: begin
                next_q.pins.ce_b = 1'b1;
                next_q.pins.we_b = 1'b1;
                next_q.pins.oe_b = 1'b1;
                next_q.pins.dq_oe = 1'b0;
                next_q.cnt = '0;
                case (q.op)
                    OP_SECTOR_ERASE, OP_CHIP_ERASE: begin
                        if (q.step == 3'd0) begin
                            next_q.cmd = (q.op == OP_CHIP_ERASE) ? CMD_CHIP_SETUP : CMD_SECTOR_SETUP;
                            next_q.step = 3'd1;
                            next_q.state = S_WR_ADDR;
                        end else if (q.step == 3'd1) begin
                            // Execute always directly follows its own setup
                            next_q.cmd = (q.op == OP_CHIP_ERASE) ? CMD_CHIP_EXEC : CMD_SECTOR_EXEC;
                            next_q.step = 3'd2;
                            next_q.timer = '0;
                            next_q.state = S_WR_ADDR;
                        end else if (q.step == 3'd2) begin
                            next_q.state = S_RD;
                        end else begin
                            next_q.state = S_IDLE;
                            next_q.resp.busy = 1'b0;
                            next_q.resp.done = 1'b1;
                        end
                    end
                    OP_ABORT: begin
                        if (q.step == 3'd0) begin
                            next_q.cmd = CMD_RESET;
                            next_q.step = 3'd1;
                            next_q.result = RES_OK;
                            next_q.state = S_WR_ADDR;
                        end else begin
                            next_q.state = S_IDLE;
                            next_q.resp.busy = 1'b0;
                            next_q.resp.done = 1'b1;
                            next_q.resp.result = RES_OK;
                        end
                    end
                    default: begin
                        if (q.step < 3'(UNLOCK_READS)) begin
                            next_q.addr = UNLOCK_ADDR[q.step];
                            next_q.state = S_RD;
                        end else begin
                            next_q.state = S_IDLE;
                            next_q.resp.busy = 1'b0;
                            next_q.resp.done = 1'b1;
                            next_q.resp.result = RES_OK;
                        end
                    end
                endcase
            end
            S_WR_ADDR: begin
                // Address settles before the strobe falls
                next_q.pins.ce_b = 1'b0;
                next_q.pins.addr = q.addr;
                next_q.pins.dq_out = q.cmd;
                next_q.pins.dq_oe = 1'b1;
                // A reset write launched from a poll read arrives with the read count still set
                next_q.cnt = '0;
                next_q.state = S_WR_PULSE;
            end
            S_WR_PULSE: begin
                next_q.pins.we_b = 1'b0;
                next_q.cnt = q.cnt + CNT_W'(1);
                if (q.cnt == CNT_W'(WE_PULSE_CYC - 1)) begin
                    next_q.state = S_WR_END;
                end
            end
            S_WR_END: begin
                // Both strobes rise together with data still driven
                next_q.pins.we_b = 1'b1;
                next_q.pins.ce_b = 1'b1;
                next_q.state = S_NEXT;
            end
            S_RD: begin
                next_q.pins.ce_b = 1'b0;
                next_q.pins.oe_b = 1'b0;
                next_q.pins.addr = q.addr;
                next_q.pins.dq_oe = 1'b0;
                next_q.cnt = q.cnt + CNT_W'(1);
                if (q.cnt == CNT_W'(READ_ACCESS_CYC)) begin
                    next_q.state = S_RD_END;
                    next_q.pins.oe_b = 1'b1;
                    next_q.pins.ce_b = 1'b1;
                    if (q.op == OP_UNLOCK) begin
                        next_q.step = q.step + 3'd1;
                    end else begin
                        next_q.prev_valid = 1'b1;
                        next_q.prev_toggle = i_dq[TOGGLE_STATUS_BIT];
                        if (poll_done) begin
                            next_q.result = RES_OK;
                            next_q.step = 3'd3;
                        end else if (i_abort || q.timer >= limit) begin
                            // Reset command stops the erase; sector or array may be partial
                            next_q.result = i_abort ? RES_ABORTED : RES_TIMEOUT;
                            next_q.cmd = CMD_RESET;
                            next_q.step = 3'd3;
                            next_q.state = S_WR_ADDR;
                        end
                    end
                end
            end
            S_RD_END: begin
                next_q.cnt = '0;
                next_q.resp.result = q.result;
                next_q.state = S_NEXT;
            end
            default: begin
                next_q.state = S_IDLE;
            end
        endcase
        if (q.state == S_NEXT && q.step == 3'd3 && q.op != OP_ABORT && q.op != OP_UNLOCK) begin
            next_q.resp.result = q.result;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            q <= '0;
            q.pins.ce_b <= 1'b1;
            q.pins.we_b <= 1'b1;
            q.pins.oe_b <= 1'b1;
        end else if (i_en) begin
            q <= next_q;
        end
    end

    assign o_resp = q.resp;
    assign o_pins = q.pins;
endmodule : flash_erase_host

/* tb/flash_erase_host_assertions.sv */
module flash_erase_host_assertions #(
    parameter int unsigned SECTOR_LIMIT = 200,
    parameter int unsigned CHIP_LIMIT = 1000
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_en,
    input wire flash_host_pkg::host_req_t i_req,
    input wire logic i_abort,
    input wire flash_host_pkg::host_resp_t o_resp,
    input wire logic [flash_host_pkg::DATA_W-1:0] i_dq,
    input wire flash_host_pkg::flash_pins_t o_pins
);
    import flash_host_pkg::*;
    int unsigned busy_cnt;
    always_ff @(posedge i_clk) begin
        busy_cnt <= (!i_rst_b || !o_resp.busy) ? 0 : busy_cnt + 1;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    property p_we_pulse;
        $fell(o_pins.we_b) |-> !o_pins.we_b[*5] ##1 o_pins.we_b;
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write strobe width wrong");
    property p_we_qual;
        !o_pins.we_b |-> o_pins.oe_b && !o_pins.ce_b && o_pins.dq_oe;
    endproperty
    a_we_qual: assert property (p_we_qual) else $error("write strobe without select");
    property p_wr_stable;
        !o_pins.we_b |-> $stable(o_pins.addr) && $stable(o_pins.dq_out);
    endproperty
    a_wr_stable: assert property (p_wr_stable) else $error("bus moved under strobe");
    property p_data_hold;
        $rose(o_pins.we_b) && $past(i_rst_b) |-> o_pins.dq_oe;
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data dropped at strobe end");
    property p_read_len;
        $fell(o_pins.oe_b) |-> !o_pins.oe_b[*5] ##1 !o_pins.oe_b[*5] ##1 o_pins.oe_b;
    endproperty
    a_read_len: assert property (p_read_len) else $error("read length wrong");
    property p_read_qual;
        !o_pins.oe_b |-> !o_pins.ce_b && o_pins.we_b && !o_pins.dq_oe;
    endproperty
    a_read_qual: assert property (p_read_qual) else $error("read cycle malformed");
    property p_done_pulse;
        o_resp.done |=> !o_resp.done && !o_resp.busy;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
    property p_accept;
        i_en && i_req.valid && !o_resp.busy && !o_resp.done && !$past(o_resp.done) && $past(i_rst_b) |=> o_resp.busy;
    endproperty
    a_accept: assert property (p_accept) else $error("request not taken");
    property p_busy_bound;
        busy_cnt <= CHIP_LIMIT + 64;
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("operation overran");
    c_ok: cover property (o_resp.done && o_resp.result == RES_OK);
    c_abort: cover property (o_resp.done && o_resp.result == RES_ABORTED);
    c_tmo: cover property (o_resp.done && o_resp.result == RES_TIMEOUT);
endmodule : flash_erase_host_assertions

bind flash_erase_host flash_erase_host_assertions #(.SECTOR_LIMIT(SECTOR_LIMIT), .CHIP_LIMIT(CHIP_LIMIT)) i_chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_en(i_en), .i_req(i_req), .i_abort(i_abort),
    .o_resp(o_resp), .i_dq(i_dq), .o_pins(o_pins));

/* tb/flash_dev_model.sv */
module flash_dev_model #(
    parameter int SECTOR_NS = 1500,
    parameter int CHIP_NS = 3000
) (
    // Pins from the host
    input wire flash_host_pkg::flash_pins_t i_pins,
    // Read data
    output logic [7:0] o_dq
);
    timeunit 1ns;
    timeprecision 1ns;
    import flash_host_pkg::*;
    logic [7:0] mem [int];
    logic [7:0] dflt = 8'h00;
    logic [7:0] setup = 8'h00;
    logic [7:0] last = 8'h00;
    logic [7:0] rd;
    logic [6:0][18:0] hist = '0;
    logic [18:0] wa = '0;
    logic locked = 1'b1;
    logic busy = 1'b0;
    logic tog = 1'b0;
    int gen = 0;
    wire wr = !i_pins.ce_b && !i_pins.we_b;

    function automatic logic [7:0] peek(input int a);
        return mem.exists(a) ? mem[a] : dflt;
    endfunction : peek

    task automatic run(input logic chip);
        int g;
        int sec;
        setup = 8'h00;
        busy = 1'b1;
        gen++;
        g = gen;
        sec = int'(wa[18:8]) * SECTOR_BYTES;
        fork
            begin
                #(chip ? CHIP_NS : SECTOR_NS);
                if (gen == g) begin
                    if (chip) begin
                        mem.delete();
                        dflt = 8'hFF;
                    end else begin
                        for (int i = 0; i < SECTOR_BYTES; i++) mem[sec + i] = 8'hFF;
                    end
                    busy = 1'b0;
                end
            end
        join_none
    endtask : run

    always @(posedge wr) wa = i_pins.addr;
    always @(negedge wr) begin
        if (busy && i_pins.dq_out == CMD_RESET) begin
            busy = 1'b0;
            gen++;
        end else if (locked || busy) begin
            setup = 8'h00;
        end else if (setup == CMD_SECTOR_SETUP && i_pins.dq_out == CMD_SECTOR_EXEC) begin
            run(1'b0);
        end else if (setup == CMD_CHIP_SETUP && i_pins.dq_out == CMD_CHIP_EXEC) begin
            run(1'b1);
        end else begin
            setup = (i_pins.dq_out inside {CMD_SECTOR_SETUP, CMD_CHIP_SETUP}) ? i_pins.dq_out : 8'h00;
        end
    end
    always @(negedge i_pins.oe_b) tog = busy ? ~tog : tog;
    always @(posedge i_pins.oe_b) begin
        last = o_dq;
        hist = {i_pins.addr, hist[6:1]};
        if (hist == UNLOCK_ADDR) locked = 1'b0;
    end
    // Released bus shows the complement of the last byte read, never the byte itself
    always @(i_pins or busy or tog or dflt or last) begin
        rd = peek(int'(i_pins.addr));
        if (i_pins.ce_b || i_pins.oe_b) o_dq = ~last;
        else if (busy) o_dq = {~rd[7], tog, rd[5:0]};
        else o_dq = rd;
    end
endmodule : flash_dev_model

/* tb/flash_command_erase_control_tb.sv */
module flash_command_erase_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import flash_host_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_en = 1'b1;
    logic i_abort = 1'b0;
    host_req_t i_req = '0;
    host_resp_t o_resp;
    flash_pins_t o_pins;
    logic [7:0] dq;
    int num_errors = 0;
    int checked = 0;
    result_t exp_q [$];
    logic [18:0] a;

    flash_erase_host #(.SECTOR_LIMIT(200), .CHIP_LIMIT(1000)) i_dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_en(i_en), .i_req(i_req), .i_abort(i_abort),
        .o_resp(o_resp), .i_dq(dq), .o_pins(o_pins));
    flash_dev_model i_dev (.i_pins(o_pins), .o_dq(dq));

    initial begin
        forever #10 i_clk = ~i_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            num_errors++;
            $display("ERROR %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic complete_run();
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    task automatic run_op(input op_t op, input logic [18:0] ad, input result_t res);
        int n;
        exp_q.push_back(res);
        i_req <= '{1'b1, op, ad};
        @(negedge i_clk);
        i_req.valid <= 1'b0;
        n = 0;
        while (o_resp.done !== 1'b1 && n < 4000) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 4000) check(0, 1);
        @(negedge i_clk);
    endtask : run_op

    always @(negedge i_clk) begin
        if (o_resp.done === 1'b1) begin
            if (exp_q.size() == 0) check(1, 0);
            else check(o_resp.result, exp_q.pop_front());
        end
    end

    initial begin
        #200000;
        num_errors++;
        complete_run();
    end

    initial begin
        void'($urandom(90));
        a = 19'($urandom());
        repeat (2) @(negedge i_clk);
        i_rst_b <= 1'b1;
        check({o_pins.ce_b, o_pins.we_b, o_pins.oe_b, o_pins.dq_oe, o_resp.busy}, 5'h1c);
        run_op(OP_SECTOR_ERASE, a, RES_TIMEOUT);
        check(i_dev.peek(int'(a)), 8'h00);
        run_op(OP_UNLOCK, 19'h0, RES_OK);
        // A frozen host must not start anything
        i_en <= 1'b0;
        i_req <= '{1'b1, OP_ABORT, 19'h0};
        repeat (3) @(negedge i_clk);
        check({o_resp.busy, o_pins.ce_b}, 2'b01);
        i_req.valid <= 1'b0;
        i_en <= 1'b1;
        @(negedge i_clk);
        for (int k = 0; k < 2; k++) begin
            run_op(OP_SECTOR_ERASE, a, RES_OK);
            check(i_dev.peek(int'({a[18:8], 8'hFF})), 8'hFF);
        end
        check(i_dev.peek(int'(a ^ 19'h0100)), 8'h00);
        i_abort <= 1'b1;
        run_op(OP_SECTOR_ERASE, a ^ 19'h0200, RES_ABORTED);
        i_abort <= 1'b0;
        check(i_dev.peek(int'(a ^ 19'h0200)), 8'h00);
        run_op(OP_ABORT, a, RES_OK);
        check(i_dev.peek(int'(a)), 8'hFF);
        check(i_dev.peek(int'(a ^ 19'h0200)), 8'h00);
        run_op(OP_CHIP_ERASE, a, RES_OK);
        check(i_dev.peek(int'(a ^ 19'h0200)), 8'hFF);
        complete_run();
    end
endmodule : flash_command_erase_control_tb
